// ### logic/lpgd_pkg.sv
// Package with register map, field positions, reset values and timing constants of the LED dimmer
package lpgd_pkg;
    localparam logic [3:0] ADDR_OUTPUT_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_FIRST_STAGED = 4'h2;
    localparam logic [3:0] ADDR_LAST_STAGED = 4'h8;
    localparam int STAGED_COUNT = 7;
    localparam logic [2:0] IDX_GROUP_DUTY = 3'h4;
    localparam logic [2:0] IDX_GROUP_PERIOD = 3'h5;
    localparam logic [2:0] IDX_OUTPUT_STATE = 3'h6;
    localparam int CHANNELS = 4;

    localparam int BIT_GROUP_BLINK = 5;
    localparam int BIT_OUTPUT_INVERT = 4;
    localparam int BIT_UPDATE_ON_ACK = 3;
    localparam int BIT_TOTEM_POLE = 2;
    localparam logic [7:0] CONFIG_WRITE_MASK = 8'h3f;

    localparam logic [7:0] CONFIG_RESET = 8'h01;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [7:0] GROUP_DUTY_RESET = 8'hff;
    localparam logic [7:0] GROUP_PERIOD_RESET = 8'h00;
    localparam logic [7:0] OUTPUT_STATE_RESET = 8'h00;

    localparam logic [1:0] STATE_OFF = 2'h0;
    localparam logic [1:0] STATE_FULL_ON = 2'h1;
    localparam logic [1:0] STATE_INDIVIDUAL = 2'h2;
    localparam logic [1:0] STATE_GROUP = 2'h3;

    localparam logic [7:0] FAST_BLINK_LIMIT = 8'h04;

    localparam int CLK_HZ = 200000000;
    localparam int PWM_STEPS = 256;
    localparam int FAST_PWM_HZ = 6250;
    localparam int GROUP_DIM_HZ = 190;
    localparam int BLINK_BASE_HZ = 24;
    localparam int FAST_STEP_CYC = CLK_HZ / (FAST_PWM_HZ * PWM_STEPS);
    localparam int DIM_STEP_CYC = CLK_HZ / (GROUP_DIM_HZ * PWM_STEPS);
    localparam int BLINK_BASE_CYC = CLK_HZ / (BLINK_BASE_HZ * PWM_STEPS);
endpackage

// ### logic/lpgd_timing_if.sv
// Interface carrying the shared PWM phases and group level to the channel logic
`timescale 1ns/100ps
`default_nettype none
interface lpgd_timing_if;
    logic [7:0] fast_phase;
    logic [7:0] slow_phase;
    logic group_on;
    logic group_blink;
    modport src (output fast_phase, output slow_phase, output group_on, output group_blink);
    modport dst (input fast_phase, input slow_phase, input group_on, input group_blink);
endinterface
`default_nettype wire

// ### logic/lpgd_chan.sv
// One LED channel: selects its level from state code, duty and the shared group level
`timescale 1ns/100ps
`default_nettype none
module lpgd_chan (
    // Shared timing
    lpgd_timing_if.dst tim,
    // Channel settings
    input wire logic [1:0] state_code,
    input wire logic [7:0] duty,
    // Channel level, high while the LED is lit
    output logic led_on
);
    wire logic slow_pwm;
    wire logic fast_pwm;
    wire logic group_pwm;

    assign slow_pwm = tim.slow_phase < duty; // [R6] [R8]
    assign fast_pwm = tim.fast_phase < {duty[7:2], 2'b00}; // [R7]
    assign group_pwm = (tim.group_blink ? slow_pwm : fast_pwm) & tim.group_on; // [R9] [R11]

    always_comb
    begin
        case (state_code) // [R15]
            lpgd_pkg::STATE_OFF: led_on = 1'b0;
            lpgd_pkg::STATE_FULL_ON: led_on = 1'b1;
            lpgd_pkg::STATE_INDIVIDUAL: led_on = slow_pwm; // [R6] [R14]
            lpgd_pkg::STATE_GROUP: led_on = group_pwm; // [R14]
            default: led_on = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ### logic/lpgd_top.sv
// Four-channel LED brightness generator with group dimming and blinking
// Functional notes
// R1: Config bit 5 clear dims the group, set blinks it using the group registers.
// R2: Config bit 4 set inverts the level driven on every LED output.
// R3: Config bit 3 clear applies new settings at STOP, set applies at byte acknowledge.
// R4: The STOP-or-ACK staging covers only registers 02h through 08h.
// R5: Config bit 2 clear makes outputs open-drain, set makes them totem-pole.
// R6: State code 10 gives a 1.5625 kHz PWM with duty equal to value over 256.
// R7: Group dimming runs channel PWM at 6.25 kHz using the six upper duty bits.
// R8: Group blinking runs channel PWM at 1.5625 kHz using all eight duty bits.
// R9: Group dimming adds a 190 Hz group PWM and ignores the group period register.
// R10: Dimming group duty uses the upper four bits followed by four zeros, over 256.
// R11: Blinking uses group duty as on/off ratio and group period as blink period.
// R12: Fast blink range uses the six upper group duty bits.
// R13: Slow blink range uses all eight group duty bits.
// R14: Only channels with state code 11 follow the group controller.
// R15: State code 00 off, 01 fully on, 10 individual PWM, 11 individual plus group.
// R16: Blink period is group period value plus one, divided by 24, in seconds.
// R17: Group period values 0 to 3 are the fast blink range, 4 and above slow.
`timescale 1ns/100ps
`default_nettype none
module lpgd_top #(
    parameter int DIM_STEP_CYC = lpgd_pkg::DIM_STEP_CYC,
    parameter int BLINK_BASE_CYC = lpgd_pkg::BLINK_BASE_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register writes from the bus byte engine, same clock domain
    input wire logic wr_strobe,
    input wire logic [3:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic bus_stop,
    // Register reads
    input wire logic [3:0] rd_addr,
    output logic [7:0] rd_data,
    // LED pins, output value and output enable
    output logic [3:0] led_out,
    output logic [3:0] led_oe
);
    // Decodes a register number inside the staged window
    function automatic logic is_staged(input logic [3:0] addr);
        is_staged = (addr >= lpgd_pkg::ADDR_FIRST_STAGED) && (addr <= lpgd_pkg::ADDR_LAST_STAGED);
    endfunction

    // Decodes the output configuration register number
    function automatic logic is_config(input logic [3:0] addr);
        is_config = addr == lpgd_pkg::ADDR_OUTPUT_CONFIG;
    endfunction

    // Position of a staged register in the written and working copies
    function automatic logic [2:0] staged_index(input logic [3:0] addr);
        staged_index = 3'(addr - lpgd_pkg::ADDR_FIRST_STAGED);
    endfunction

    // Reset value of a staged register by its index
    function automatic logic [7:0] staged_reset(input int idx);
        if (idx == int'(lpgd_pkg::IDX_GROUP_DUTY))
        begin
            staged_reset = lpgd_pkg::GROUP_DUTY_RESET;
        end
        else if (idx == int'(lpgd_pkg::IDX_GROUP_PERIOD))
        begin
            staged_reset = lpgd_pkg::GROUP_PERIOD_RESET;
        end
        else if (idx == int'(lpgd_pkg::IDX_OUTPUT_STATE))
        begin
            staged_reset = lpgd_pkg::OUTPUT_STATE_RESET;
        end
        else
        begin
            staged_reset = lpgd_pkg::DUTY_RESET;
        end
    endfunction

    lpgd_timing_if tim ();

    // Register state
    logic [7:0] config_ff;
    logic [7:0] nxt_config;
    logic [7:0] shadow_ff [lpgd_pkg::STAGED_COUNT];
    logic [7:0] active_ff [lpgd_pkg::STAGED_COUNT];
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;

    // Decode of the write and read paths
    wire logic wr_config;
    wire logic wr_staged;
    wire logic [2:0] wr_idx;
    wire logic rd_config;
    wire logic rd_staged;
    wire logic [2:0] rd_idx;
    wire logic apply_on_ack;
    wire logic apply_now;

    assign wr_config = wr_strobe && is_config(wr_addr);
    assign wr_staged = wr_strobe && is_staged(wr_addr); // [R4]
    assign wr_idx = staged_index(wr_addr);
    assign rd_config = is_config(rd_addr);
    assign rd_staged = is_staged(rd_addr);
    assign rd_idx = staged_index(rd_addr);
    assign apply_on_ack = config_ff[lpgd_pkg::BIT_UPDATE_ON_ACK]; // [R3]
    // The whole working copy loads at once, so with config bit 3 clear the pins never show half of a new staged setting
    assign apply_now = bus_stop || (wr_staged && apply_on_ack); // [R3]
    // Config takes effect at once; only the staged registers wait for STOP or ACK
    assign nxt_config = wr_config ? (wr_data & lpgd_pkg::CONFIG_WRITE_MASK) : config_ff;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            config_ff <= lpgd_pkg::CONFIG_RESET;
        end
        else
        begin
            config_ff <= nxt_config;
        end
    end

    // Staged registers: written value held, copied to the working copy at STOP or ACK
    genvar gi;
    generate
        for (gi = 0; gi < lpgd_pkg::STAGED_COUNT; gi++)
        begin : g_staged
            // Reset value fixed at elaboration, so the reset branch loads a constant
            localparam logic [7:0] RESET_VAL = staged_reset(gi);
            wire logic hit;
            wire logic [7:0] nxt_shadow;
            wire logic [7:0] nxt_active;

            assign hit = wr_staged && (wr_idx == 3'(gi));
            assign nxt_shadow = hit ? wr_data : shadow_ff[gi];
            // A write in the same cycle as STOP is carried into the working copy
            assign nxt_active = apply_now ? nxt_shadow : active_ff[gi]; // [R3] [R4]

            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                begin
                    shadow_ff[gi] <= RESET_VAL;
                    active_ff[gi] <= RESET_VAL;
                end
                else
                begin
                    shadow_ff[gi] <= nxt_shadow;
                    active_ff[gi] <= nxt_active;
                end
            end
        end
    endgenerate

    // Read path returns the last written values, so software sees its own write before STOP
    // Unmapped register numbers read as zero
    always_comb
    begin
        nxt_rd_data = 8'h00;
        if (rd_config)
        begin
            nxt_rd_data = config_ff;
        end
        else if (rd_staged)
        begin
            nxt_rd_data = shadow_ff[rd_idx];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data_ff <= 8'h00;
        end
        else
        begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;

    // Working settings
    wire logic group_blink;
    wire logic invert;
    wire logic totem;
    wire logic [7:0] group_duty;
    wire logic [7:0] group_period;
    wire logic [7:0] output_state;

    assign group_blink = config_ff[lpgd_pkg::BIT_GROUP_BLINK]; // [R1]
    assign invert = config_ff[lpgd_pkg::BIT_OUTPUT_INVERT]; // [R2]
    assign totem = config_ff[lpgd_pkg::BIT_TOTEM_POLE]; // [R5]
    assign group_duty = active_ff[lpgd_pkg::IDX_GROUP_DUTY];
    assign group_period = active_ff[lpgd_pkg::IDX_GROUP_PERIOD];
    assign output_state = active_ff[lpgd_pkg::IDX_OUTPUT_STATE];

    // Channel PWM timebase: 6.25 kHz phase from the low bits, 1.5625 kHz from the high bits
    logic [15:0] fast_div_ff;
    logic [9:0] chan_cnt_ff;
    wire logic fast_tick;
    wire logic [15:0] nxt_fast_div;
    wire logic [9:0] nxt_chan_cnt;

    assign fast_tick = fast_div_ff == 16'(lpgd_pkg::FAST_STEP_CYC - 1);
    assign nxt_fast_div = fast_tick ? 16'h0000 : 16'(fast_div_ff + 16'h0001);
    assign nxt_chan_cnt = fast_tick ? 10'(chan_cnt_ff + 10'h001) : chan_cnt_ff;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            fast_div_ff <= 16'h0000;
            chan_cnt_ff <= 10'h000;
        end
        else
        begin
            fast_div_ff <= nxt_fast_div;
            chan_cnt_ff <= nxt_chan_cnt;
        end
    end

    assign tim.fast_phase = chan_cnt_ff[7:0]; // [R7]
    assign tim.slow_phase = chan_cnt_ff[9:2]; // [R6] [R8]

    // Group dimming timebase at 190 Hz
    // Group timebases free-run; a new setting takes hold at the next phase compare
    logic [15:0] dim_div_ff;
    logic [7:0] dim_phase_ff;
    wire logic dim_tick;
    wire logic [15:0] nxt_dim_div;
    wire logic [7:0] nxt_dim_phase;

    assign dim_tick = dim_div_ff >= 16'(DIM_STEP_CYC - 1); // [R9]
    assign nxt_dim_div = dim_tick ? 16'h0000 : 16'(dim_div_ff + 16'h0001);
    assign nxt_dim_phase = dim_tick ? 8'(dim_phase_ff + 8'h01) : dim_phase_ff;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            dim_div_ff <= 16'h0000;
            dim_phase_ff <= 8'h00;
        end
        else
        begin
            dim_div_ff <= nxt_dim_div;
            dim_phase_ff <= nxt_dim_phase;
        end
    end

    // Blink timebase: one phase step per (period value + 1) base steps of 1/(24*256) s
    logic [15:0] blink_div_ff;
    logic [7:0] blink_sub_ff;
    logic [7:0] blink_phase_ff;
    wire logic blink_base_tick;
    wire logic blink_step;
    wire logic [15:0] nxt_blink_div;
    wire logic [7:0] nxt_blink_sub;
    wire logic [7:0] nxt_blink_phase;

    assign blink_base_tick = blink_div_ff >= 16'(BLINK_BASE_CYC - 1);
    assign blink_step = blink_base_tick && (blink_sub_ff >= group_period); // [R16]
    assign nxt_blink_div = blink_base_tick ? 16'h0000 : 16'(blink_div_ff + 16'h0001);
    assign nxt_blink_sub = blink_step ? 8'h00 : (blink_base_tick ? 8'(blink_sub_ff + 8'h01) : blink_sub_ff);
    assign nxt_blink_phase = blink_step ? 8'(blink_phase_ff + 8'h01) : blink_phase_ff;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            blink_div_ff <= 16'h0000;
            blink_sub_ff <= 8'h00;
            blink_phase_ff <= 8'h00;
        end
        else
        begin
            blink_div_ff <= nxt_blink_div;
            blink_sub_ff <= nxt_blink_sub;
            blink_phase_ff <= nxt_blink_phase;
        end
    end

    // Group level: each threshold keeps only the duty bits that its range resolves
    wire logic fast_blink;
    wire logic [7:0] dim_threshold;
    wire logic [7:0] fine_threshold;
    wire logic [7:0] blink_threshold;
    wire logic dim_on;
    wire logic blink_on;

    assign fast_blink = group_period < lpgd_pkg::FAST_BLINK_LIMIT; // [R17]
    assign dim_threshold = {group_duty[7:4], 4'h0}; // [R10]
    assign fine_threshold = {group_duty[7:2], 2'b00}; // [R12]
    assign blink_threshold = fast_blink ? fine_threshold : group_duty; // [R12] [R13]
    assign dim_on = dim_phase_ff < dim_threshold; // [R10]
    assign blink_on = blink_phase_ff < blink_threshold; // [R11]
    assign tim.group_on = group_blink ? blink_on : dim_on; // [R1] [R11]
    assign tim.group_blink = group_blink; // [R1]

    // Channels share one timebase, so all LEDs switch in phase
    wire logic [3:0] led_on;

    generate
        for (gi = 0; gi < lpgd_pkg::CHANNELS; gi++)
        begin : g_chan
            lpgd_chan u_chan (
                .tim(tim),
                .state_code(output_state[2 * gi + 1 -: 2]),
                .duty(active_ff[gi]),
                .led_on(led_on[gi])
            );
        end
    endgenerate

    // Pin drive: lit LED pulls the pin low unless inverted
    // A dark LED in open-drain mode releases its pin to the pull-up, but pulls it low when inverted
    logic [3:0] led_out_ff;
    logic [3:0] led_oe_ff;
    wire logic [3:0] pin_level;
    wire logic [3:0] nxt_led_out;
    wire logic [3:0] nxt_led_oe;

    assign pin_level = ~(led_on ^ {4{invert}}); // [R2]
    assign nxt_led_out = totem ? pin_level : 4'h0; // [R5]
    assign nxt_led_oe = totem ? 4'hf : ~pin_level; // [R5]

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            led_out_ff <= 4'h0;
            led_oe_ff <= 4'h0;
        end
        else
        begin
            led_out_ff <= nxt_led_out;
            led_oe_ff <= nxt_led_oe;
        end
    end

    assign led_out = led_out_ff;
    assign led_oe = led_oe_ff;
endmodule
`default_nettype wire

// ### testbench/lpgd_led_load.sv
// LED load model: resolves each pin with a pull-up and reports which LEDs are lit
`timescale 1ns/100ps
`default_nettype none
module lpgd_led_load (
    // Pin drive from the device
    input wire logic [3:0] led_out,
    input wire logic [3:0] led_oe,
    // Resolved pin level and lit LEDs
    output logic [3:0] pin_level,
    output logic [3:0] lit
);
    // A released pin is pulled up, so an LED hung from the supply stays dark
    assign pin_level = (led_oe & led_out) | ~led_oe;
    assign lit = ~pin_level;
endmodule
`default_nettype wire

// ### testbench/lpgd_properties.sv
// Port-level properties of the LED dimmer
`timescale 1ns/100ps
`default_nettype none
module lpgd_properties (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic wr_strobe,
    input wire logic [3:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic bus_stop,
    input wire logic [3:0] rd_addr,
    input wire logic [7:0] rd_data,
    // LED pins
    input wire logic [3:0] led_out,
    input wire logic [3:0] led_oe
);
    logic [7:0] cfg_ff, stg_os_ff, wrk_os_ff, prev_cfg_ff, prev_os_ff, nxt_stg_os;
    logic staged_wr;
    logic [3:0] pin_lvl;
    assign staged_wr = wr_strobe && wr_addr >= 4'h2 && wr_addr <= 4'h8;
    assign nxt_stg_os = (wr_strobe && wr_addr == 4'h8) ? wr_data : stg_os_ff;
    // Pins seen now were computed from the settings one cycle back
    assign pin_lvl = prev_cfg_ff[2] ? led_out : ~led_oe;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_ff <= 8'h01;
            stg_os_ff <= 8'h00;
            wrk_os_ff <= 8'h00;
            prev_cfg_ff <= 8'h01;
            prev_os_ff <= 8'h00;
        end
        else
        begin
            if (wr_strobe && wr_addr == 4'h1)
            begin
                cfg_ff <= wr_data & 8'h3f;
            end
            stg_os_ff <= nxt_stg_os;
            if (bus_stop || (staged_wr && cfg_ff[3]))
            begin
                wrk_os_ff <= nxt_stg_os;
            end
            prev_cfg_ff <= cfg_ff;
            prev_os_ff <= wrk_os_ff;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    for (genvar i = 0; i < 4; i++)
    begin : g_ch
        a_off_level: assert property (prev_os_ff[2*i+:2] == 2'h0 |-> pin_lvl[i] == ~prev_cfg_ff[4])
            else $error("off channel shows wrong pin level");
        a_full_on_level: assert property (prev_os_ff[2*i+:2] == 2'h1 |-> pin_lvl[i] == prev_cfg_ff[4])
            else $error("full-on channel shows wrong pin level");
    end
    a_open_drain_low: assert property (!prev_cfg_ff[2] |-> led_out == 4'h0)
        else $error("open-drain pin driven high");
    a_totem_drive: assert property (prev_cfg_ff[2] |-> led_oe == 4'hf)
        else $error("totem-pole pin not driven");
    a_cfg_readback: assert property (rd_addr == 4'h1 && !wr_strobe |=> rd_data == cfg_ff)
        else $error("config readback wrong");
    a_state_readback: assert property (rd_addr == 4'h8 && !wr_strobe |=> rd_data == stg_os_ff)
        else $error("output state readback wrong");
    a_unmapped_zero: assert property ((rd_addr == 4'h0 || rd_addr > 4'h8) |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_pins_steady: assert property ((prev_os_ff & 8'haa) == 8'h00 && $stable(prev_os_ff) && $stable(prev_cfg_ff)
        |-> $stable(led_out) && $stable(led_oe)) else $error("pins moved without a settings change");
endmodule
bind lpgd_top lpgd_properties i_lpgd_properties (.core_clk(core_clk), .rst(rst), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data), .bus_stop(bus_stop), .rd_addr(rd_addr), .rd_data(rd_data),
    .led_out(led_out), .led_oe(led_oe));
`default_nettype wire

// ### testbench/tb.sv
// Testbench of the LED dimmer: register access, staging, pin drive and PWM counts
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("Error %s expected %0h seen %0h", n, e, g); \
        end \
    end
module tb;
    localparam int DIM = 8;
    localparam int BLK = 4;
    logic core_clk, rst, wr_strobe, bus_stop;
    logic [3:0] wr_addr, rd_addr, led_out, led_oe, pin_level, lit;
    logic [7:0] wr_data, rd_data;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] cnt [4];
    int bper [3] = '{0, 3, 4};
    // Lit cycles per blink period: on phases times (period + 1) * BLK cycles per phase
    int bexp [3] = '{512, 2048, 2620};
    logic [3:0] raddr [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hf};
    logic [7:0] rexp [11] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    lpgd_top #(.DIM_STEP_CYC(DIM), .BLINK_BASE_CYC(BLK)) i_lpgd_top (.core_clk(core_clk), .rst(rst),
        .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .bus_stop(bus_stop), .rd_addr(rd_addr),
        .rd_data(rd_data), .led_out(led_out), .led_oe(led_oe));
    lpgd_led_load i_lpgd_led_load (.led_out(led_out), .led_oe(led_oe), .pin_level(pin_level), .lit(lit));
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_errors++;
            end_sim();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr_strobe <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge core_clk);
        wr_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        rd_addr <= a;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("rd_data", e, rd_data)
    endtask
    task automatic settle();
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    // Skip one full period so a changed step length has settled, then count lit cycles
    task automatic measure(input int n);
        repeat (n) @(posedge core_clk);
        cnt = '{default: 0};
        repeat (n)
        begin
            @(negedge core_clk);
            for (int i = 0; i < 4; i++)
            begin
                cnt[i] += 32'(lit[i]);
            end
        end
    endtask
    initial
    begin
        rst = 1'b1;
        wr_strobe = 1'b0;
        wr_addr = 4'h0;
        wr_data = 8'h00;
        bus_stop = 1'b0;
        rd_addr = 4'h0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        foreach (raddr[k]) rd(raddr[k], rexp[k]);
        $display("test reset_values done");
        wr(4'h1, 8'hff);
        rd(4'h1, 8'h3f);
        wr(4'h1, 8'h00);
        wr(4'h8, 8'h55);
        rd(4'h8, 8'h55);
        `CHK("lit before stop", 4'h0, lit)
        @(posedge core_clk);
        bus_stop <= 1'b1;
        @(posedge core_clk);
        bus_stop <= 1'b0;
        settle();
        `CHK("lit after stop", 4'hf, lit)
        $display("test staging done");
        wr(4'h1, 8'h10);
        settle();
        `CHK("lit inverted", 4'h0, lit)
        `CHK("pin inverted", 4'hf, pin_level)
        wr(4'h1, 8'h04);
        settle();
        `CHK("led_oe totem", 4'hf, led_oe)
        `CHK("lit totem", 4'hf, lit)
        wr(4'h1, 8'h0c);
        wr(4'h8, 8'h00);
        settle();
        `CHK("lit on ack", 4'h0, lit)
        $display("test output_drive done");
        wr(4'h2, 8'hff);
        wr(4'h3, 8'hff);
        wr(4'h6, 8'h80);
        wr(4'h8, 8'h9b);
        measure(DIM * 256);
        `CHK("ch0 dim", 1024, cnt[0])
        `CHK("ch1 individual", DIM * 256, cnt[1])
        `CHK("ch2 full on", DIM * 256, cnt[2])
        `CHK("ch3 zero duty", 0, cnt[3])
        wr(4'h6, 8'h8f);
        wr(4'h7, 8'h04);
        measure(DIM * 256);
        `CHK("ch0 dim low bits", 1024, cnt[0])
        $display("test group_dim done");
        wr(4'h1, 8'h2c);
        wr(4'h6, 8'h83);
        foreach (bper[k])
        begin
            wr(4'h7, bper[k][7:0]);
            measure((bper[k] + 1) * BLK * 256);
            `CHK("ch0 blink", bexp[k], cnt[0])
        end
        $display("test group_blink done");
        end_sim();
    end
endmodule
`default_nettype wire
